// [common/pm_pkg.sv]
package pm_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 125_000_000;
    localparam int SAMPLE_HZ   = 32_000;
    localparam int SAMPLE_DIV  = CLK_HZ / SAMPLE_HZ;
    localparam logic [11:0] DIV_LAST = 12'(SAMPLE_DIV - 1);
    localparam int SCLK_MAX_HZ = 10_000_000;
    // ------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------
    localparam logic [5:0] BIT_HDR = 6'h08;
    localparam logic [5:0] BIT_END = 6'h28;
    // ------------------------------------------------------------
    // serial register space
    // ------------------------------------------------------------
    localparam logic [6:0] NV_LO    = 7'h0B;
    localparam logic [6:0] NV_HI    = 7'h0F;
    localparam logic [6:0] FREE_LO  = 7'h10;
    localparam logic [6:0] FREE_HI  = 7'h13;
    localparam logic [6:0] SH_LO    = 7'h1B;
    localparam logic [6:0] SH_HI    = 7'h1F;
    localparam logic [6:0] ACC_ADDR = 7'h2F;
    // value is arbitrary
    localparam logic [31:0] ACCESS_CODE = 32'h4F70_656E;
    localparam int NV_WORDS = 9;
    localparam int SH_WORDS = 5;
    localparam int CFG_IDX  = 4;
    localparam logic [1:0] ECC_OK = 2'h0;
    localparam int BYP_BIT  = 24;
    localparam int N_LSB    = 14;
    localparam int N_W      = 10;
    localparam int COMM_BIT = 25;
    localparam logic [9:0] N_MIN = 10'h004;
    // ------------------------------------------------------------
    // ahb register map
    // ------------------------------------------------------------
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_WIN    = 8'h04;
    localparam logic [7:0] A_CTRL   = 8'h08;
    localparam logic [7:0] A_FRAMES = 8'h0C;
    localparam logic       CTRL_RST = 1'b1;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PM_LOAD = 3'b001,
        PM_RUN  = 3'b010,
        PM_EXEC = 3'b100
    } pm_state_e;
    typedef struct packed {
        logic       rd;
        logic [6:0] addr;
        logic [31:0] data;
    } pm_cmd_s;
    typedef struct packed {
        logic        valid;
        logic [15:0] len;
    } pm_win_s;
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
        logic vzc;
    } pm_pins_s;
endpackage

// [hdl/pm_sync3.sv]
`timescale 1ns/1ps
module pm_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // pins in, settled levels out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } pm_sync_s;
    pm_sync_s r_reg;
    pm_sync_s r_next;

    // a bit moves only once stages two and three agree
    always_comb begin
        r_next    = r_reg;
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.q  = (r_reg.s2 & r_reg.s3)
                  | (r_reg.q & (r_reg.s2 | r_reg.s3));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= {INIT, INIT, INIT, INIT};
        end else begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.q;
endmodule // pm_sync3

// [hdl/pm_win.sv]
`timescale 1ns/1ps
module pm_win (
    // clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // sample rate, zero crossing, config
    input  wire logic                    tick,
    input  wire logic                    zc,
    input  wire logic                    fixed,
    input  wire logic [pm_pkg::N_W-1:0]  n_cfg,
    // window result
    output pm_pkg::pm_win_s              win
);
    typedef struct packed {
        logic            zc_d;
        logic            fixed_d;
        logic            seen;
        logic [15:0]     cnt;
        pm_pkg::pm_win_s w;
    } pm_wst_s;
    pm_wst_s     r_reg;
    pm_wst_s     r_next;
    logic [15:0] n_eff;
    logic [15:0] twice;

    always_comb begin
        n_eff = (n_cfg < pm_pkg::N_MIN) ? {6'h0, pm_pkg::N_MIN}
                                        : {6'h0, n_cfg};
        twice = {n_eff[14:0], 1'b0};
        r_next         = r_reg;
        r_next.zc_d    = zc;
        r_next.fixed_d = fixed;
        if (tick && r_reg.cnt != 16'hFFFF) begin
            r_next.cnt = r_reg.cnt + 16'h1;
        end
        // a mode change restarts the window from scratch
        if (fixed != r_reg.fixed_d) begin
            r_next.cnt     = 16'h0;
            r_next.seen    = 1'b0;
            r_next.w.valid = 1'b0;
        end else if (fixed) begin
            r_next.w.len = n_eff;
            if (r_reg.cnt >= twice) begin
                r_next.w.valid = 1'b1;
            end
        end else if (zc && !r_reg.zc_d) begin
            if (r_reg.seen) begin
                r_next.w.len   = r_reg.cnt;
                r_next.w.valid = 1'b1;
            end
            r_next.seen = 1'b1;
            r_next.cnt  = 16'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign win = r_reg.w;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_fixed_len: assert property ((fixed && r_reg.fixed_d)
        |=> r_reg.w.len == $past(n_eff))
        else $error("fixed window length wrong");
    a_fixed_first: assert property ((fixed && $rose(r_reg.w.valid))
        |-> $past(r_reg.cnt) >= $past(twice))
        else $error("fixed window valid too early");
    a_dyn_len: assert property ((!fixed && !r_reg.fixed_d && zc
        && !r_reg.zc_d && r_reg.seen)
        |=> r_reg.w.len == $past(r_reg.cnt) && r_reg.w.valid)
        else $error("dynamic window not taken from crossing");
    c_fixed_valid: cover property (fixed && $rose(r_reg.w.valid));
endmodule // pm_win

// [hdl/pm_spi_dev.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module pm_spi_dev (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // serial link
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    // voltage zero-crossing comparator
    input  wire logic        vzc
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        pm_pkg::pm_state_e st;
        logic [2:0]        lidx;
        logic [4:0][25:0]  sh;
        logic              comm_spi;
        logic              unlocked;
        logic              sclk_d;
        logic              cs_d;
        logic [5:0]        bcnt;
        logic [7:0]        hdr;
        logic [31:0]       shin;
        logic [31:0]       sout;
        logic [31:0]       resp;
        pm_pkg::pm_cmd_s   cmd;
        logic              miso;
        logic              miso_oe;
        logic [11:0]       div;
        logic              tick;
        logic              meas_en;
        logic              a_sel;
        logic              a_wr;
        logic [7:0]        a_addr;
        logic [31:0]       hrdata;
        logic [15:0]       frames;
        logic              hreadyout;
    } pm_dev_s;

    pm_dev_s          r_reg;
    pm_dev_s          r_next;
    pm_pkg::pm_pins_s pin;
    pm_pkg::pm_win_s  win;
    logic [25:0]      nv_mem [0:pm_pkg::NV_WORDS-1];
    logic             nv_we;
    logic [3:0]       nv_idx;
    logic [25:0]      nv_q;
    logic [6:0]       nv_off;
    logic [6:0]       sh_off;
    logic             rise;
    logic             acc;
    logic             ctrl_fwd;
    logic             nv_hit;
    logic             free_hit;
    logic             sh_hit;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    // three stages plus agreement cost about four cycles, which
    // fits inside a half period of a 10 MHz serial clock
    pm_sync3 #(
        .W    (4),
        .INIT (4'h4)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({sclk, cs_n, mosi, vzc}),
        .q       (pin)
    );

    // ------------------------------------------------------------
    // measurement window
    // ------------------------------------------------------------
    pm_win u_win (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (r_reg.tick),
        .zc      (pin.vzc),
        .fixed   (r_reg.sh[pm_pkg::CFG_IDX][pm_pkg::BYP_BIT]),
        .n_cfg   (r_reg.sh[pm_pkg::CFG_IDX]
                  [pm_pkg::N_LSB +: pm_pkg::N_W]),
        .win     (win)
    );

    // ------------------------------------------------------------
    // nonvolatile store
    // ------------------------------------------------------------
    // blank factory contents; no reset, so words survive hresetn
    initial begin
        for (int i = 0; i < pm_pkg::NV_WORDS; i++) begin
            nv_mem[i] = '0;
        end
    end

    always_ff @(posedge hclk) begin
        if (nv_we) begin
            nv_mem[nv_idx] <= r_reg.cmd.data[25:0];
        end
    end

    assign nv_off = r_reg.cmd.addr - pm_pkg::NV_LO;
    assign sh_off = r_reg.cmd.addr - pm_pkg::SH_LO;
    assign nv_idx = (r_reg.st == pm_pkg::PM_LOAD) ? {1'b0, r_reg.lidx}
                                                  : nv_off[3:0];
    assign nv_q   = nv_mem[nv_idx];
    assign nv_hit = r_reg.cmd.addr >= pm_pkg::NV_LO
                 && r_reg.cmd.addr <= pm_pkg::NV_HI;
    assign free_hit = r_reg.cmd.addr >= pm_pkg::FREE_LO
                   && r_reg.cmd.addr <= pm_pkg::FREE_HI;
    assign sh_hit = r_reg.cmd.addr >= pm_pkg::SH_LO
                 && r_reg.cmd.addr <= pm_pkg::SH_HI;
    assign rise   = pin.sclk && !r_reg.sclk_d;
    assign acc    = hsel && hready && htrans[1] && hsize == 3'h2;
    assign ctrl_fwd = (r_reg.a_sel && r_reg.a_wr
                    && r_reg.a_addr == pm_pkg::A_CTRL) ? hwdata[0]
                                                      : r_reg.meas_en;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        nv_we  = 1'b0;
        // sample-rate enable for the window logic
        r_next.tick = 1'b0;
        if (r_reg.div == pm_pkg::DIV_LAST) begin
            r_next.div  = 12'h0;
            r_next.tick = r_reg.meas_en;
        end else begin
            r_next.div = r_reg.div + 12'h1;
        end

        case (r_reg.st)
            pm_pkg::PM_LOAD: begin
                r_next.sh[r_reg.lidx] = nv_q;
                if (r_reg.lidx == 3'(pm_pkg::SH_WORDS - 1)) begin
                    // protocol select is read once, here only
                    r_next.comm_spi = ~nv_q[pm_pkg::COMM_BIT];
                    r_next.miso_oe  = ~nv_q[pm_pkg::COMM_BIT];
                    r_next.st       = pm_pkg::PM_RUN;
                end else begin
                    r_next.lidx = r_reg.lidx + 3'h1;
                end
            end
            pm_pkg::PM_EXEC: begin
                r_next.st     = pm_pkg::PM_RUN;
                r_next.frames = r_reg.frames + 16'h1;
                r_next.resp   = 32'h0;
                if (r_reg.cmd.rd) begin
                    // data bits of a read frame are dropped
                    if (nv_hit || free_hit) begin
                        r_next.resp = {4'h0, pm_pkg::ECC_OK,
                                       nv_q};
                    end else if (sh_hit) begin
                        r_next.resp = {6'h0,
                                       r_reg.sh[sh_off[2:0]]};
                    end else if (r_reg.cmd.addr == pm_pkg::ACC_ADDR) begin
                        r_next.resp = {31'h0, r_reg.unlocked};
                    end
                end else if (nv_hit) begin
                    nv_we = r_reg.unlocked;
                end else if (free_hit) begin
                    nv_we = 1'b1;
                end else if (sh_hit) begin
                    r_next.sh[sh_off[2:0]] = r_reg.cmd.data[25:0];
                end else if (r_reg.cmd.addr == pm_pkg::ACC_ADDR) begin
                    if (r_reg.cmd.data == pm_pkg::ACCESS_CODE) begin
                        r_next.unlocked = 1'b1;
                    end
                end
            end
            pm_pkg::PM_RUN: begin
                r_next.st = pm_pkg::PM_RUN;
            end
            default: begin
                r_next.st = pm_pkg::PM_LOAD;
            end
        endcase

        // serial link; miso changes right after each rising edge from the eighth on,
        // so the host samples it a whole clock period later
        r_next.sclk_d = pin.sclk;
        r_next.cs_d   = pin.cs_n;
        if (pin.cs_n) begin
            r_next.bcnt = 6'h0;
            // shorter frames are dropped whole; longer ones run on their first 40 bits
            if (!r_reg.cs_d && r_reg.bcnt == pm_pkg::BIT_END
                && r_reg.comm_spi) begin
                r_next.cmd.rd   = r_reg.hdr[0];
                r_next.cmd.addr = r_reg.hdr[7:1];
                r_next.cmd.data = r_reg.shin;
                r_next.st       = pm_pkg::PM_EXEC;
            end
        end else if (rise && r_reg.comm_spi
                     && r_reg.bcnt != pm_pkg::BIT_END) begin
            r_next.bcnt = r_reg.bcnt + 6'h1;
            if (r_reg.bcnt < pm_pkg::BIT_HDR) begin
                r_next.hdr = {r_reg.hdr[6:0], pin.mosi};
            end else begin
                r_next.shin = {r_reg.shin[30:0], pin.mosi};
            end
            if (r_reg.bcnt == pm_pkg::BIT_HDR - 6'h1) begin
                r_next.miso = r_reg.resp[31];
                r_next.sout = {r_reg.resp[30:0], 1'b0};
            end else if (r_reg.bcnt >= pm_pkg::BIT_HDR) begin
                r_next.miso = r_reg.sout[31];
                r_next.sout = {r_reg.sout[30:0], 1'b0};
            end
        end

        // ahb: zero wait states, read data registered in addr phase
        if (r_reg.a_sel && r_reg.a_wr
            && r_reg.a_addr == pm_pkg::A_CTRL) begin
            r_next.meas_en = hwdata[0];
        end
        r_next.a_sel  = acc;
        r_next.a_wr   = hwrite;
        r_next.a_addr = (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF;
        if (acc && !hwrite) begin
            r_next.hrdata = 32'h0;
            if (haddr[31:8] == 24'h0) begin
                case (haddr[7:0])
                    pm_pkg::A_STATUS: begin
                        r_next.hrdata = {27'h0, win.valid,
                            r_reg.sh[pm_pkg::CFG_IDX][pm_pkg::BYP_BIT],
                            r_reg.comm_spi,
                            r_reg.st != pm_pkg::PM_LOAD,
                            r_reg.unlocked};
                    end
                    pm_pkg::A_WIN: begin
                        r_next.hrdata = {16'h0, win.len};
                    end
                    pm_pkg::A_CTRL: begin
                        r_next.hrdata = {31'h0, ctrl_fwd};
                    end
                    pm_pkg::A_FRAMES: begin
                        r_next.hrdata = {16'h0, r_reg.frames};
                    end
                    default: begin
                        r_next.hrdata = 32'h0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg           <= '0;
            r_reg.st        <= pm_pkg::PM_LOAD;
            r_reg.cs_d      <= 1'b1;
            r_reg.meas_en   <= pm_pkg::CTRL_RST;
            r_reg.hreadyout <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign hrdata    = r_reg.hrdata;
    assign hreadyout = r_reg.hreadyout;
    assign hresp     = 1'b0 & r_reg.hreadyout;
    assign miso      = r_reg.miso;
    assign miso_oe   = r_reg.miso_oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic        loaded;
    logic        exec;
    logic        unl;
    logic        resp_msb;
    logic [25:0] cmd_low;
    assign loaded   = r_reg.st != pm_pkg::PM_LOAD;
    assign exec     = r_reg.st == pm_pkg::PM_EXEC;
    assign unl      = r_reg.unlocked;
    assign resp_msb = r_reg.resp[31];
    assign cmd_low  = r_reg.cmd.data[25:0];

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_load_copy: assert property ((!loaded && r_reg.lidx == 3'h4)
        |=> loaded && r_reg.sh[pm_pkg::CFG_IDX] == $past(nv_q))
        else $error("shadow not loaded at power-up");
    a_mode_held: assert property ($past(loaded)
        |-> $stable(r_reg.comm_spi))
        else $error("protocol select changed at run time");
    a_miso_kept: assert property ((loaded && r_reg.comm_spi)
        |-> miso_oe [*4])
        else $error("serial output released");
    a_cmd_take: assert property ((pin.cs_n && !r_reg.cs_d
        && r_reg.bcnt == pm_pkg::BIT_END && r_reg.comm_spi)
        |=> exec && r_reg.cmd.rd == $past(r_reg.hdr[0])
        && r_reg.cmd.addr == $past(r_reg.hdr[7:1]))
        else $error("header not decoded");
    a_short_drop: assert property ((pin.cs_n && !r_reg.cs_d
        && r_reg.bcnt != pm_pkg::BIT_END) |=> !exec)
        else $error("short frame executed");
    a_first_bit: assert property ((rise && !pin.cs_n && r_reg.comm_spi
        && r_reg.bcnt == 6'h07) |=> miso == $past(resp_msb))
        else $error("first data bit not previous result");
    a_acc_reply: assert property ((exec && r_reg.cmd.rd
        && r_reg.cmd.addr == pm_pkg::ACC_ADDR)
        |=> r_reg.resp == {31'h0, $past(unl)})
        else $error("read result wrong");
    a_read_pure: assert property ((exec && r_reg.cmd.rd) |-> !nv_we
        ##1 $stable(r_reg.sh))
        else $error("read frame stored data");
    a_locked_nv: assert property (nv_we |-> unl || free_hit)
        else $error("customer space written while locked");
    a_free_nv: assert property ((exec && !r_reg.cmd.rd && free_hit)
        |-> nv_we)
        else $error("free space write refused");
    a_shadow_now: assert property ((exec && !r_reg.cmd.rd
        && r_reg.cmd.addr == pm_pkg::SH_HI)
        |=> r_reg.sh[pm_pkg::CFG_IDX] == $past(cmd_low))
        else $error("shadow write not applied");

    c_read: cover property (exec && r_reg.cmd.rd && nv_hit);
    c_nv_write: cover property (nv_we && nv_hit);
    c_unlock: cover property ($rose(r_reg.unlocked));
endmodule // pm_spi_dev

// [sim/pm_host.sv]
`timescale 1ns/1ps
module pm_host (
    // bench clock, paces the link
    input  wire logic hclk,
    // serial pins, sole master and sole slave on this bus
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // ------------------------------------------------------------
    // one frame: address, direction, 32 data bits, msb first
    // ------------------------------------------------------------
    // pins move only just after a bench clock edge, so the device
    // never sees a pin change on its own sampling edge
    task automatic frame(input logic [39:0] tx, output logic [31:0] rx);
        @(posedge hclk);
        cs_n <= 1'b0;
        for (int i = 39; i >= 0; i--) begin
            mosi <= tx[i];
            repeat (4) @(posedge hclk);
            sclk <= 1'b1; // 64 ns period, above the 10 MHz rate ceiling
            if (i < 32) rx[i] = miso;
            repeat (4) @(posedge hclk);
            sclk <= 1'b0;
        end
        // a released data line shows the inverse of the last bit
        mosi <= ~tx[0];
        repeat (25) @(posedge hclk);
        cs_n <= 1'b1;
        repeat (25) @(posedge hclk);
    endtask
endmodule // pm_host

// [sim/pm_spi_dev_tb.sv]
`timescale 1ns/1ps
module pm_spi_dev_tb;
    typedef struct packed {
        logic            rst;
        pm_pkg::pm_cmd_s c;
        logic [31:0]     e;
    } pm_row_s;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        vzc = 1'b0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, sclk, cs_n, mosi, miso, miso_oe;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    pm_row_s     rows [16];
    localparam logic [31:0] AC = pm_pkg::ACCESS_CODE;
    always #4 hclk = ~hclk;
    pm_spi_dev i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .vzc(vzc));
    pm_host i_host (.hclk(hclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d bad %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d = 32'h0);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        chk("oe_in_reset", 32'h0, 32'(miso_oe));
        hresetn <= 1'b1;
        repeat (40) @(posedge hclk);
    endtask
    function automatic pm_row_s r(logic s, w, logic [6:0] a,
                                  logic [31:0] d, e);
        return '{s, '{w, a, d}, e};
    endfunction
    // a hang ends the run as a failure
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // frame table, then window and register checks
    // ------------------------------------------------------------
    initial begin
        rows[0]  = r(1'b1, 1'b1, 7'h2F, 32'h0, 32'h0);
        rows[1]  = r(1'b0, 1'b0, 7'h2F, AC, 32'h0);
        rows[2]  = r(1'b0, 1'b1, 7'h2F, 32'h0, 32'h0);
        rows[3]  = r(1'b0, 1'b0, 7'h0B, 32'h02BC1234, 32'h1);
        rows[4]  = r(1'b0, 1'b0, 7'h10, 32'h0155AAAA, 32'h0);
        rows[5]  = r(1'b0, 1'b0, 7'h1B, 32'h000000FF, 32'h0);
        rows[6]  = r(1'b0, 1'b1, 7'h1B, 32'h0, 32'h0);
        rows[7]  = r(1'b0, 1'b1, 7'h10, 32'h0, 32'hFF);
        rows[8]  = r(1'b0, 1'b1, 7'h0B, 32'h0, 32'h0155AAAA);
        rows[9]  = r(1'b0, 1'b1, 7'h2F, 32'h0, 32'h02BC1234);
        rows[10] = r(1'b1, 1'b1, 7'h1B, 32'h0, 32'h0);
        rows[11] = r(1'b0, 1'b0, 7'h0B, 32'h5555, 32'h02BC1234);
        rows[12] = r(1'b0, 1'b1, 7'h0B, 32'h0, 32'h0);
        rows[13] = r(1'b0, 1'b1, 7'h2F, 32'h0, 32'h02BC1234);
        rows[14] = r(1'b0, 1'b0, 7'h1F, 32'h01008000, 32'h0);
        rows[15] = r(1'b0, 1'b1, 7'h1F, 32'hFFFFFFFF, 32'h0);
        foreach (rows[i]) begin
            if (rows[i].rst) do_reset();
            i_host.frame({rows[i].c.addr, rows[i].c.rd, rows[i].c.data},
                         rd);
            if (!rows[i].rst) chk("reply", rows[i].e, rd);
        end
        chk("oe_after", 32'h1, 32'(miso_oe));
        @(posedge hclk);
        ahb(1'b0, pm_pkg::A_FRAMES);
        chk("frames", 32'h6, rd & 32'hFFFF);
        ahb(1'b0, 8'h40);
        chk("unmapped", 32'h0, rd);
        ahb(1'b0, pm_pkg::A_CTRL);
        chk("ctrl", 32'h1, rd);
        // fixed count 2 is floored to the minimum, ready after twice it
        repeat (5 * pm_pkg::SAMPLE_DIV) @(posedge hclk);
        ahb(1'b0, pm_pkg::A_STATUS);
        chk("early", 32'h0, rd & 32'h10);
        repeat (3 * pm_pkg::SAMPLE_DIV) @(posedge hclk);
        ahb(1'b0, pm_pkg::A_STATUS);
        chk("status", 32'h18, rd & 32'h18);
        ahb(1'b0, pm_pkg::A_WIN);
        chk("win", 32'(pm_pkg::N_MIN), rd);
        // back to crossing mode; rises two sample periods plus one
        // cycle apart enclose exactly two divider ticks
        i_host.frame({7'h1F, 1'b0, 32'h0}, rd);
        chk("read_kept", 32'h01008000, rd);
        vzc <= 1'b1;
        repeat (8) @(posedge hclk);
        vzc <= 1'b0;
        repeat (2 * pm_pkg::SAMPLE_DIV - 7) @(posedge hclk);
        vzc <= 1'b1;
        repeat (8) @(posedge hclk);
        ahb(1'b0, pm_pkg::A_WIN);
        chk("dyn_win", 32'h2, rd);
        ahb(1'b0, pm_pkg::A_STATUS);
        chk("dyn_status", 32'h10, rd & 32'h18);
        ahb(1'b1, pm_pkg::A_CTRL, 32'h0);
        ahb(1'b0, pm_pkg::A_CTRL);
        chk("ctrl_off", 32'h0, rd);
        chk("hresp", 32'h0, 32'(hresp));
        end_sim();
    end
endmodule // pm_spi_dev_tb
